// [dv/chc_ctrl_regs_chk.sv]
`timescale 1ns/100ps
// ******
// port checker of the control register block
// ******
module chc_ctrl_regs_chk
  import chc_pkg::*;
#(
  parameter bit HANDSHAKE_VARIANT = 1'b1
) (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic REG_RESET,
  input wire logic WATCHDOG_EXPIRE,
  input wire logic BOOST_OUTPUT_ENABLE,
  input wire logic PLUGIN,
  input wire chc_pkg::chc_det_s DETECT_RESULT,
  input wire logic ADC_START,
  input wire logic DETECT_START,
  input wire logic HOST_MODE,
  input wire chc_pkg::chc_ctrl_s CTRL
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  logic det_busy; // mirrors detection in flight, starts one edge late
  // helper: a done pulse only counts while detection runs
  always_ff @(posedge CORE_CLK) begin
    if (SRST || REG_RESET || WATCHDOG_EXPIRE) begin
      det_busy <= 1'b0;
    end else if (DETECT_START) begin
      det_busy <= 1'b1;
    end else if (DETECT_RESULT.done) begin
      det_busy <= 1'b0;
    end
  end

  // watchdog expiry with no register reset or detection done in the same cycle
  sequence wd_s;
    WATCHDOG_EXPIRE && !REG_RESET && !DETECT_RESULT.done;
  endsequence
  // dedicated charger found by the handshake variant
  sequence dcp_done_s;
    HANDSHAKE_VARIANT && det_busy && DETECT_RESULT.done && !REG_RESET &&
      DETECT_RESULT.kind == CHC_SRC_DEDICATED && !WATCHDOG_EXPIRE;
  endsequence

  wd_mode_a: assert property (wd_s |=> !HOST_MODE &&
      !CTRL.input_high_impedance_enable && CTRL.limit_pin_enable)
    else $error("watchdog did not restore mode bits");
  wd_keep_a: assert property (wd_s |=>
      $stable(CTRL.input_current_limit_code) &&
      $stable(CTRL.power_limit_offset_select) &&
      $stable(CTRL.input_optimizer_enable))
    else $error("watchdog touched a kept field");
  reg_rst_a: assert property (REG_RESET |=> CTRL == {8'h48,
      8'h00, 1'b1, 2'b00, 1'b1, {2{HANDSHAKE_VARIANT}}, 1'b1})
    else $error("register reset value wrong");
  det_load_a: assert property (dcp_done_s |=>
      CTRL.input_current_limit_code == 6'h3f)
    else $error("dedicated port limit not loaded");
  line_short_a: assert property (CTRL.line_short |->
      CTRL.positive_line_driver_level == 3'h0 &&
      CTRL.negative_line_driver_level == 3'h0)
    else $error("short code left a driver on");
  neg_top_a: assert property (
      CTRL.negative_line_driver_level != 3'h7)
    else $error("negative code 111 not folded");
  boost_frequency_select_a: assert property (BOOST_OUTPUT_ENABLE &&
      !REG_RESET && !WATCHDOG_EXPIRE |=>
      $stable(CTRL.boost_frequency_select))
    else $error("frequency changed in boost");
  adc_pulse_a: assert property (ADC_START |=> !ADC_START)
    else $error("conversion start longer than a cycle");
  cont_gap_a: assert property (CTRL.conversion_continuous_select &&
      ADC_START |=> !ADC_START [*8])
    else $error("extra start in continuous mode");
  det_pulse_a: assert property (DETECT_START |=> !DETECT_START [*2])
    else $error("detection start repeated");
  plug_skip_a: assert property (PLUGIN &&
      !CTRL.plugin_source_detection_enable |=> !DETECT_START)
    else $error("plug-in detection not skipped");
endmodule : chc_ctrl_regs_chk

bind chc_ctrl_regs chc_ctrl_regs_chk #(
  .HANDSHAKE_VARIANT(HANDSHAKE_VARIANT)
) chc_ctrl_regs_chk_i (
  .CORE_CLK(CORE_CLK), .SRST(SRST), .REG_RESET(REG_RESET),
  .WATCHDOG_EXPIRE(WATCHDOG_EXPIRE), .PLUGIN(PLUGIN),
  .BOOST_OUTPUT_ENABLE(BOOST_OUTPUT_ENABLE),
  .DETECT_RESULT(DETECT_RESULT), .ADC_START(ADC_START),
  .DETECT_START(DETECT_START), .HOST_MODE(HOST_MODE), .CTRL(CTRL)
);

// [dv/chc_host_model.sv]
`timescale 1ns/100ps
// ******
// host bus controller model
// ******
module chc_host_model #(
  parameter logic [6:0] ADDR = 7'h6a,
  parameter int HALF = 4
) (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_h
);
  // both lines idle high through the pull-ups
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // data moves only while the clock is low; line sampled while high
  task automatic bit_io(input logic b, output logic r);
    sda_h <= b;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    r = sda;
    scl <= 1'b0;
    tick(HALF);
  endtask : bit_io
  // start, also used as repeated start
  task automatic start;
    sda_h <= 1'b1;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_h <= 1'b0;
    tick(HALF);
    scl <= 1'b0;
    tick(HALF);
  endtask : start
  task automatic stop;
    sda_h <= 1'b0;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_h <= 1'b1;
    tick(HALF);
  endtask : stop
  // byte out msb first; ack low means taken
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, ack);
  endtask : put
  // byte in; the last byte is answered with no acknowledge
  task automatic get(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nak, r);
  endtask : get
  // single write; the host may set the force bit this way
  task automatic wr(input logic [6:0] a, input logic [7:0] ra,
                    input logic [7:0] v, output logic ack);
    logic k;
    start;
    put({a, 1'b0}, ack);
    put(ra, k);
    put(v, k);
    stop;
  endtask : wr
  // pointer write, repeated start, one byte read
  task automatic rd(input logic [7:0] ra, output logic [7:0] v);
    logic k;
    start;
    put({ADDR, 1'b0}, k);
    put(ra, k);
    start;
    put({ADDR, 1'b1}, k);
    get(1'b1, v);
    stop;
  endtask : rd
endmodule : chc_host_model

// [dv/tb_chc_ctrl_regs.sv]
`timescale 1ns/100ps
// ******
// self-checking bench of the control registers
// ******
module tb_chc_ctrl_regs;
  import chc_pkg::*;
  localparam logic [6:0] DEV = 7'h6a; // handshake variant target
  logic CORE_CLK = 1'b0;
  logic SRST = 1'b1;
  logic BOOST_OUTPUT_ENABLE = 1'b0;
  logic SOURCE_SELECT_PIN = 1'b0;
  logic ADC_DONE = 1'b0;
  logic [2:0] kick = 3'h0; // one-cycle pulses of reset, watchdog, plug
  chc_det_s DETECT_RESULT = '0;
  logic REG_RESET, WATCHDOG_EXPIRE, PLUGIN, SCL_IN, sda_h;
  logic SDA_OUT, SDA_OE, ADC_START, DETECT_START, HOST_MODE;
  chc_ctrl_s CTRL;
  wire SDA_IN = sda_h & ~(SDA_OE & ~SDA_OUT); // open-drain wire
  int errors = 0;
  int n_tests = 0;
  int n_adc = 0;
  int n_det = 0;
  int b;
  logic pend = 1'b0; // conversion in flight at the adc side
  logic slow = 1'b0; // high holds the adc answer back
  logic k;
  logic [31:0] lfsr = 32'h81ac;
  logic [7:0] v, e;
  chc_src_e kinds [5] = '{CHC_SRC_STANDARD, CHC_SRC_CHARGING,
    CHC_SRC_DEDICATED, CHC_SRC_HIGH_VOLT, CHC_SRC_UNKNOWN};
  logic [5:0] lims [5] = '{6'h08, 6'h1c, 6'h3f, 6'h1c, 6'h08};
  assign {REG_RESET, WATCHDOG_EXPIRE, PLUGIN} = kick;

  always #5 CORE_CLK = ~CORE_CLK;

  chc_ctrl_regs #(.HANDSHAKE_VARIANT(1'b1), .CONV_PERIOD_CYCLES(50))
  chc_ctrl_regs_i (.CORE_CLK(CORE_CLK), .SRST(SRST), .SCL_IN(SCL_IN),
    .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
    .REG_RESET(REG_RESET), .WATCHDOG_EXPIRE(WATCHDOG_EXPIRE),
    .BOOST_OUTPUT_ENABLE(BOOST_OUTPUT_ENABLE), .PLUGIN(PLUGIN),
    .SOURCE_SELECT_PIN(SOURCE_SELECT_PIN), .DETECT_RESULT(DETECT_RESULT),
    .ADC_DONE(ADC_DONE), .ADC_START(ADC_START),
    .DETECT_START(DETECT_START), .HOST_MODE(HOST_MODE), .CTRL(CTRL));
  chc_host_model #(.ADDR(DEV)) chc_host_model_i (.clk(CORE_CLK),
    .sda(SDA_IN), .scl(SCL_IN), .sda_h(sda_h));

  // adc side: answers each start unless held slow; counts starts
  always @(posedge CORE_CLK) begin
    if (ADC_START) begin
      pend <= 1'b1;
      n_adc <= n_adc + 1;
    end else if (ADC_DONE) begin
      pend <= 1'b0;
    end
    ADC_DONE <= pend & ~slow & ~ADC_DONE;
    if (DETECT_START) n_det <= n_det + 1;
  end

  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : rnd
  // line driver fields as decoded: short clears both, 111 reads 110
  function automatic logic [8:0] dec1(input logic [7:0] r);
    logic sh;
    logic [2:0] n;
    sh = (r[7:5] == 3'h7);
    n = (r[4:2] == 3'h7) ? 3'h6 : r[4:2];
    return {sh ? 3'h0 : r[7:5], sh ? 3'h0 : n, sh, r[1:0]};
  endfunction : dec1
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    if (errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic put_reg(input logic [7:0] ra, input logic [7:0] d);
    chc_host_model_i.wr(DEV, ra, d, k);
    check("ack", k, 1'b0);
  endtask : put_reg
  task automatic rdchk(input string w, input logic [7:0] ra,
                       input logic [7:0] x);
    logic [7:0] d;
    chc_host_model_i.rd(ra, d);
    check(w, d, x);
  endtask : rdchk
  task automatic pulse(input int i);
    kick[i] <= 1'b1;
    @(posedge CORE_CLK);
    kick <= 3'h0;
    repeat (3) @(posedge CORE_CLK);
  endtask : pulse

  // hang guard, well beyond the expected run
  initial begin
    repeat (95000) @(posedge CORE_CLK);
    errors++;
    tally_and_finish;
  end

  // main sequence
  initial begin
    repeat (8) @(posedge CORE_CLK);
    SRST <= 1'b0;
    @(posedge CORE_CLK);
    rdchk("reg0", 8'h00, 8'h48);
    rdchk("reg1", 8'h01, 8'h01);
    rdchk("reg2", 8'h02, 8'h1d);
    rdchk("beyond", 8'h15, 8'hff);
    check("host", HOST_MODE, 1'b0);
    chc_host_model_i.wr(7'h6b, 8'h00, 8'h00, k);
    check("nack", k, 1'b1);
    rdchk("reg0", 8'h00, 8'h48);
    // random values, corner codes first
    for (int i = 0; i < 12; i++) begin
      lfsr = rnd(lfsr);
      SOURCE_SELECT_PIN <= lfsr[8];
      v = (i == 0) ? 8'he0 : (i == 1) ? 8'h1c : lfsr[7:0];
      put_reg(8'h00, v);
      rdchk("reg0", 8'h00, v);
      check("c0", {CTRL[22:21], CTRL.input_current_limit_code}, v);
      put_reg(8'h01, v);
      rdchk("reg1", 8'h01, v);
      check("c1", CTRL[14:6], dec1(v));
      e = v & 8'h3d;
      put_reg(8'h02, e);
      rdchk("reg2", 8'h02, e);
      check("c2", CTRL[5:0], {1'b0, e[5:2], e[0]});
    end
    check("host", HOST_MODE, 1'b1);
    BOOST_OUTPUT_ENABLE <= 1'b1;
    put_reg(8'h02, {2'b00, ~e[5], 5'h1d});
    rdchk("freq", 8'h02, {2'b00, e[5], 5'h1d});
    BOOST_OUTPUT_ENABLE <= 1'b0;
    // one-shot conversion held busy, then answered
    slow <= 1'b1;
    b = n_adc;
    put_reg(8'h02, 8'h9d);
    rdchk("busy", 8'h02, 8'h9d);
    slow <= 1'b0;
    repeat (4) @(posedge CORE_CLK);
    rdchk("idle", 8'h02, 8'h1d);
    check("one", n_adc - b, 1);
    // continuous conversions, then stopped
    b = n_adc;
    put_reg(8'h02, 8'h5d);
    repeat (400) @(posedge CORE_CLK);
    put_reg(8'h02, 8'h1d);
    check("rate", (n_adc - b) >= 10 && (n_adc - b) <= 20, 1'b1);
    b = n_adc;
    repeat (200) @(posedge CORE_CLK);
    check("halt", n_adc - b, 0);
    rdchk("done", 8'h02, 8'h1d);
    // detection by force and by plug-in, each source kind but the non-standard one
    b = n_det;
    for (int i = 0; i < 5; i++) begin
      if (i % 2 == 1) pulse(0);
      else put_reg(8'h02, 8'h1f);
      rdchk("det", 8'h02, 8'h9f);
      DETECT_RESULT <= {1'b1, kinds[i]};
      @(posedge CORE_CLK);
      DETECT_RESULT <= '0;
      repeat (2) @(posedge CORE_CLK);
      check("load", CTRL.input_current_limit_code, lims[i]);
      rdchk("nodet", 8'h02, 8'h1d);
    end
    check("dets", n_det - b, 5);
    put_reg(8'h02, 8'h1c);
    pulse(0);
    check("skip", n_det - b, 5);
    // watchdog keeps limit, offset, optimizer and handshakes
    put_reg(8'h00, 8'hff);
    put_reg(8'h01, 8'hff);
    put_reg(8'h02, 8'h20);
    pulse(1);
    check("wd host", HOST_MODE, 1'b0);
    rdchk("wd0", 8'h00, 8'h7f);
    rdchk("wd1", 8'h01, 8'h01);
    rdchk("wd2", 8'h02, 8'h00);
    pulse(2);
    rdchk("rr0", 8'h00, 8'h48);
    rdchk("rr1", 8'h01, 8'h01);
    rdchk("rr2", 8'h02, 8'h1d);
    tally_and_finish;
  end
endmodule : tb_chc_ctrl_regs

// [rtl/chc_ctrl_regs.sv]
`timescale 1ns/100ps
`include "chc_map.svh"

module chc_ctrl_regs #(
  parameter bit HANDSHAKE_VARIANT = 1'b1,
  parameter int CONV_PERIOD_CYCLES = `CHC_CONV_PERIOD_CYC
) (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic REG_RESET,
  input wire logic WATCHDOG_EXPIRE,
  input wire logic BOOST_OUTPUT_ENABLE,
  input wire logic PLUGIN,
  input wire logic SOURCE_SELECT_PIN,
  input wire chc_pkg::chc_det_s DETECT_RESULT,
  input wire logic ADC_DONE,
  output logic ADC_START,
  output logic DETECT_START,
  output logic HOST_MODE,
  output chc_pkg::chc_ctrl_s CTRL
);
  import chc_pkg::*;

  // ****************************************
  // constants
  // ****************************************
  localparam logic [6:0] OWN_ADDR = HANDSHAKE_VARIANT ?
    `CHC_ADDR_HANDSHAKE : `CHC_ADDR_PIN_SELECT;
  localparam logic [31:0] PERIOD = 32'(CONV_PERIOD_CYCLES);
  localparam logic [5:0] LIM_500 = 6'((`CHC_LIMIT_500_MA -
    `CHC_LIMIT_OFFSET_MA) / `CHC_LIMIT_STEP_MA);
  localparam logic [5:0] LIM_1500 = 6'((`CHC_LIMIT_1500_MA -
    `CHC_LIMIT_OFFSET_MA) / `CHC_LIMIT_STEP_MA);
  localparam logic [5:0] LIM_3250 = 6'((`CHC_LIMIT_3250_MA -
    `CHC_LIMIT_OFFSET_MA) / `CHC_LIMIT_STEP_MA);

  chc_top_s r; // all state
  chc_top_s next_r; // next state
  chc_cell_s reg_src; // input source control
  chc_cell_s reg_drv; // data line driver control
  chc_cell_s reg_adc; // adc and detection control
  logic wr_en; // one-cycle host write strobe
  logic [7:0] wr_addr; // register being written
  logic [7:0] wr_data; // byte being written
  logic lim_ld; // detection result load
  logic [5:0] lim_val; // limit code to load
  logic [7:0] adc_mask; // writable stored bits of reg2

  // ****************************************
  // register read mux
  // ****************************************
  function automatic logic [7:0] read_reg(input logic [7:0] a,
                                          input chc_top_s s);
    logic [7:0] v;
    v = `CHC_READ_OTHER;
    if (a == `CHC_REG_INPUT_SOURCE) begin
      v = reg_src.q;
    end else if (a == `CHC_REG_LINE_DRIVER) begin
      v = reg_drv.q;
    end else if (a == `CHC_REG_ADC_DETECT) begin
      v = reg_adc.q;
      // busy flags replace the stored start and force bits
      v[`CHC_BIT_CONVERSION_START_BUSY] = s.adc_busy | s.det_busy;
      v[`CHC_BIT_FORCE_DET] = s.det_busy;
    end else if (a > `CHC_REG_LAST) begin
      v = `CHC_READ_BEYOND;
    end
    return v;
  endfunction : read_reg

  // ****************************************
  // detection result to limit code
  // ****************************************
  always_comb begin
    lim_ld = DETECT_RESULT.done & r.det_busy;
    lim_val = reg_src.q[5:0];
    if (HANDSHAKE_VARIANT) begin
      case (DETECT_RESULT.kind)
        CHC_SRC_STANDARD: lim_val = LIM_500;
        CHC_SRC_CHARGING: lim_val = LIM_1500;
        CHC_SRC_DEDICATED: lim_val = LIM_3250;
        CHC_SRC_HIGH_VOLT: lim_val = LIM_1500;
        CHC_SRC_UNKNOWN: lim_val = LIM_500;
        // non-standard adapters keep whatever is stored
        default: lim_val = reg_src.q[5:0];
      endcase
    end else begin
      lim_val = SOURCE_SELECT_PIN ? LIM_500 : LIM_3250;
    end
  end

  // boost frequency ignores host writes while boost runs
  assign adc_mask = BOOST_OUTPUT_ENABLE ? `CHC_ADC_HOST_MASK :
    `CHC_ADC_BOOST_MASK;

  // ****************************************
  // register cells
  // ****************************************
  chc_reg_cell #(
    .RESET_VAL(`CHC_RST_INPUT_SOURCE),
    .WD_MASK(`CHC_WD_INPUT_SOURCE)
  ) u_src (
    .clk(CORE_CLK),
    .srst(SRST),
    .reg_rst(REG_RESET),
    .wd_expire(WATCHDOG_EXPIRE),
    .we(wr_en && wr_addr == `CHC_REG_INPUT_SOURCE),
    .wmask(8'hff),
    .wdata(wr_data),
    .hw_ld(lim_ld),
    .hw_mask(`CHC_LIMIT_MASK),
    .hw_data({2'b00, lim_val}),
    .q(reg_src)
  );

  chc_reg_cell #(
    .RESET_VAL(`CHC_RST_LINE_DRIVER),
    .WD_MASK(`CHC_WD_LINE_DRIVER)
  ) u_drv (
    .clk(CORE_CLK),
    .srst(SRST),
    .reg_rst(REG_RESET),
    .wd_expire(WATCHDOG_EXPIRE),
    .we(wr_en && wr_addr == `CHC_REG_LINE_DRIVER),
    .wmask(8'hff),
    .wdata(wr_data),
    .hw_ld(1'b0),
    .hw_mask(8'h00),
    .hw_data(8'h00),
    .q(reg_drv)
  );

  chc_reg_cell #(
    .RESET_VAL(`CHC_RST_ADC_DETECT),
    .WD_MASK(`CHC_WD_ADC_DETECT)
  ) u_adc (
    .clk(CORE_CLK),
    .srst(SRST),
    .reg_rst(REG_RESET),
    .wd_expire(WATCHDOG_EXPIRE),
    .we(wr_en && wr_addr == `CHC_REG_ADC_DETECT),
    .wmask(adc_mask),
    .wdata(wr_data),
    .hw_ld(1'b0),
    .hw_mask(8'h00),
    .hw_data(8'h00),
    .q(reg_adc)
  );

  // ****************************************
  // target engine, conversion and detection
  // ****************************************
  always_comb begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic adc_req;
    logic det_req;
    logic cont;
    next_r = r;
    adc_req = 1'b0;
    det_req = 1'b0;
    wr_en = 1'b0;
    wr_addr = r.ptr;
    wr_data = r.sh;
    rise = SCL_IN & ~r.scl_q;
    fall = ~SCL_IN & r.scl_q;
    start = SCL_IN & r.scl_q & r.sda_q & ~SDA_IN;
    stop = SCL_IN & r.scl_q & ~r.sda_q & SDA_IN;
    cont = reg_adc.q[`CHC_BIT_CONV_CONT];
    next_r.scl_q = SCL_IN;
    next_r.sda_q = SDA_IN;
    next_r.adc_pulse = 1'b0;
    next_r.det_pulse = 1'b0;
    if (start) begin
      // start or repeated start always reopens address phase
      next_r.st = CHC_RX;
      next_r.ph = CHC_PH_ADDR;
      next_r.cnt = 3'd0;
      next_r.seen = 1'b0;
      next_r.sda_drv = 1'b0;
    end else if (stop) begin
      next_r.st = CHC_IDLE;
      next_r.sda_drv = 1'b0;
    end else begin
      case (r.st)
        CHC_IDLE: begin
          next_r.sda_drv = 1'b0;
        end
        CHC_RX: begin
          if (rise) begin
            next_r.sh = {r.sh[6:0], SDA_IN};
            next_r.cnt = r.cnt + 3'd1;
            next_r.seen = (r.cnt == 3'd7);
          end else if (fall && r.seen) begin
            next_r.seen = 1'b0;
            next_r.st = CHC_RX_ACK;
            next_r.sda_drv = 1'b1;
            case (r.ph)
              CHC_PH_ADDR: begin
                if (r.sh[7:1] != OWN_ADDR) begin
                  next_r.st = CHC_IDLE;
                  next_r.sda_drv = 1'b0;
                end
                next_r.rw = r.sh[0];
              end
              CHC_PH_REG: begin
                next_r.ptr = r.sh;
              end
              default: begin
                // data byte: write and step the pointer
                wr_en = 1'b1;
                next_r.ptr = r.ptr + 8'd1;
              end
            endcase
          end
        end
        CHC_RX_ACK: begin
          if (rise) begin
            next_r.seen = 1'b1;
          end else if (fall && r.seen) begin
            next_r.seen = 1'b0;
            next_r.cnt = 3'd0;
            next_r.sda_drv = 1'b0;
            next_r.st = CHC_RX;
            if (r.ph == CHC_PH_ADDR && r.rw) begin
              next_r.st = CHC_TX;
              next_r.sh = read_reg(r.ptr, r);
              next_r.sda_drv = ~next_r.sh[7];
              next_r.ptr = r.ptr + 8'd1;
            end else if (r.ph == CHC_PH_ADDR) begin
              next_r.ph = CHC_PH_REG;
            end else begin
              next_r.ph = CHC_PH_DATA;
            end
          end
        end
        CHC_TX: begin
          if (fall) begin
            next_r.cnt = r.cnt + 3'd1;
            if (r.cnt == 3'd7) begin
              next_r.st = CHC_TX_ACK;
              next_r.sda_drv = 1'b0;
            end else begin
              next_r.sh = {r.sh[6:0], 1'b0};
              next_r.sda_drv = ~r.sh[6];
            end
          end
        end
        CHC_TX_ACK: begin
          if (rise) begin
            next_r.seen = 1'b1;
            next_r.rw = ~SDA_IN; // host acknowledge kept here
          end else if (fall && r.seen) begin
            next_r.seen = 1'b0;
            next_r.cnt = 3'd0;
            if (r.rw) begin
              next_r.st = CHC_TX;
              next_r.sh = read_reg(r.ptr, r);
              next_r.sda_drv = ~next_r.sh[7];
              next_r.ptr = r.ptr + 8'd1;
            end else begin
              // not acknowledged: wait for stop or restart
              next_r.st = CHC_IDLE;
            end
          end
        end
        default: begin
          next_r.st = CHC_IDLE;
          next_r.sda_drv = 1'b0;
        end
      endcase
    end

    // any write puts the device under host control; expiry wins a tie
    if (WATCHDOG_EXPIRE) begin
      next_r.host_mode = 1'b0;
    end else if (wr_en) begin
      next_r.host_mode = 1'b1;
    end

    // conversion requests; host start ignored in continuous mode
    adc_req = wr_en && wr_addr == `CHC_REG_ADC_DETECT &&
      wr_data[`CHC_BIT_CONVERSION_START_BUSY] && !cont;
    next_r.cont_q = cont;
    if (!cont) begin
      next_r.tmr = 32'd0; // repeats stop, busy finishes alone
    end else if (r.tmr == 32'd0) begin
      next_r.tmr = PERIOD - 32'd1;
      adc_req = 1'b1;
    end else begin
      next_r.tmr = r.tmr - 32'd1;
    end
    if (ADC_DONE) begin
      next_r.adc_busy = 1'b0;
    end
    // a new start wins over a done in the same cycle
    if (adc_req && (!r.adc_busy || ADC_DONE)) begin
      next_r.adc_busy = 1'b1;
      next_r.adc_pulse = 1'b1;
    end

    // detection requests from the force bit or from plug-in
    det_req = (wr_en && wr_addr == `CHC_REG_ADC_DETECT &&
      wr_data[`CHC_BIT_FORCE_DET]) ||
      (PLUGIN && reg_adc.q[`CHC_BIT_AUTO_DET]);
    if (lim_ld) begin
      next_r.det_busy = 1'b0;
    end
    if (det_req && (!r.det_busy || lim_ld)) begin
      next_r.det_busy = 1'b1;
      next_r.det_pulse = 1'b1;
    end

    // register reset and watchdog drop both busy bits
    if (REG_RESET || WATCHDOG_EXPIRE) begin
      next_r.adc_busy = 1'b0;
      next_r.det_busy = 1'b0;
      next_r.tmr = 32'd0;
    end
  end

  // state register
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      r <= '0;
      r.st <= CHC_IDLE;
      r.ph <= CHC_PH_ADDR;
      r.scl_q <= 1'b1;
      r.sda_q <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign SDA_OUT = 1'b0;
  assign SDA_OE = r.sda_drv;
  assign ADC_START = r.adc_pulse;
  assign DETECT_START = r.det_pulse;
  assign HOST_MODE = r.host_mode;

  // field decode
  always_comb begin
    CTRL.input_high_impedance_enable = reg_src.q[7];
    CTRL.limit_pin_enable = reg_src.q[6];
    CTRL.input_current_limit_code = reg_src.q[5:0];
    CTRL.line_short = reg_drv.q[7:5] == 3'h7;
    CTRL.positive_line_driver_level = CTRL.line_short ? 3'h0 :
      reg_drv.q[7:5];
    CTRL.negative_line_driver_level = CTRL.line_short ? 3'h0 :
      (reg_drv.q[4:2] == 3'h7 ? 3'h6 : reg_drv.q[4:2]);
    CTRL.twelve_volt_request_enable = reg_drv.q[1];
    CTRL.power_limit_offset_select = reg_drv.q[0];
    CTRL.conversion_continuous_select = reg_adc.q[6];
    CTRL.boost_frequency_select = reg_adc.q[5];
    CTRL.input_optimizer_enable = reg_adc.q[4];
    CTRL.high_voltage_charger_handshake_enable =
      HANDSHAKE_VARIANT & reg_adc.q[3];
    CTRL.adjustable_adapter_handshake_enable =
      HANDSHAKE_VARIANT & reg_adc.q[2];
    CTRL.plugin_source_detection_enable = reg_adc.q[0];
  end

endmodule : chc_ctrl_regs

// [rtl/chc_map.svh]
`ifndef CHC_MAP_SVH
`define CHC_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define CHC_REG_INPUT_SOURCE 8'h00
`define CHC_REG_LINE_DRIVER 8'h01
`define CHC_REG_ADC_DETECT 8'h02
`define CHC_REG_LAST 8'h14
`define CHC_READ_BEYOND 8'hff
`define CHC_READ_OTHER 8'h00

// ****************************************
// reset values and watchdog restore masks
// ****************************************
`define CHC_RST_INPUT_SOURCE 8'h48
`define CHC_RST_LINE_DRIVER 8'h01
`define CHC_RST_ADC_DETECT 8'h1d
`define CHC_WD_INPUT_SOURCE 8'hc0
`define CHC_WD_LINE_DRIVER 8'hfe
`define CHC_WD_ADC_DETECT 8'he2

// ****************************************
// target addresses
// ****************************************
`define CHC_ADDR_HANDSHAKE 7'h6a
`define CHC_ADDR_PIN_SELECT 7'h6b

// ****************************************
// field positions
// ****************************************
`define CHC_BIT_CONVERSION_START_BUSY 7
`define CHC_BIT_CONV_CONT 6
`define CHC_BIT_BOOST_FREQUENCY_SELECT 5
`define CHC_BIT_FORCE_DET 1
`define CHC_BIT_AUTO_DET 0
`define CHC_LIMIT_MASK 8'h3f
`define CHC_ADC_HOST_MASK 8'h5d
`define CHC_ADC_BOOST_MASK 8'h7d

// ****************************************
// input current limit levels in mA
// ****************************************
`define CHC_LIMIT_OFFSET_MA 100
`define CHC_LIMIT_STEP_MA 50
`define CHC_LIMIT_500_MA 500
`define CHC_LIMIT_1500_MA 1500
`define CHC_LIMIT_3250_MA 3250

// ****************************************
// timing
// ****************************************
`define CHC_CLK_KHZ 100000
`define CHC_CONV_PERIOD_MS 1000
`define CHC_CONV_PERIOD_CYC (`CHC_CONV_PERIOD_MS * `CHC_CLK_KHZ)

`endif

// [rtl/chc_pkg.sv]
package chc_pkg;

  // ****************************************
  // target engine states and byte phases
  // ****************************************
  typedef enum logic [2:0] {
    CHC_IDLE, CHC_RX, CHC_RX_ACK, CHC_TX, CHC_TX_ACK
  } chc_state_e;

  typedef enum logic [1:0] {
    CHC_PH_ADDR, CHC_PH_REG, CHC_PH_DATA
  } chc_phase_e;

  // source kinds reported by the detection logic
  typedef enum logic [2:0] {
    CHC_SRC_STANDARD, CHC_SRC_CHARGING, CHC_SRC_DEDICATED,
    CHC_SRC_HIGH_VOLT, CHC_SRC_UNKNOWN, CHC_SRC_NONSTANDARD
  } chc_src_e;

  // detection result carrier
  typedef struct packed {
    logic done;
    chc_src_e kind;
  } chc_det_s;

  // decoded control fields handed to the analog side
  typedef struct packed {
    logic input_high_impedance_enable;
    logic limit_pin_enable;
    logic [5:0] input_current_limit_code;
    logic [2:0] positive_line_driver_level;
    logic [2:0] negative_line_driver_level;
    logic line_short;
    logic twelve_volt_request_enable;
    logic power_limit_offset_select;
    logic conversion_continuous_select;
    logic boost_frequency_select;
    logic input_optimizer_enable;
    logic high_voltage_charger_handshake_enable;
    logic adjustable_adapter_handshake_enable;
    logic plugin_source_detection_enable;
  } chc_ctrl_s;

  // one register cell
  typedef struct packed {
    logic [7:0] q;
  } chc_cell_s;

  // whole state of the top module
  typedef struct packed {
    chc_state_e st;
    chc_phase_e ph;
    logic scl_q;
    logic sda_q;
    logic [7:0] sh;
    logic [2:0] cnt;
    logic seen;
    logic rw;
    logic [7:0] ptr;
    logic sda_drv;
    logic host_mode;
    logic adc_busy;
    logic det_busy;
    logic adc_pulse;
    logic det_pulse;
    logic cont_q;
    logic [31:0] tmr;
  } chc_top_s;

endpackage : chc_pkg

// [rtl/chc_reg_cell.sv]
`timescale 1ns/100ps
`include "chc_map.svh"

// one 8-bit control register with reset, watchdog and hardware load
module chc_reg_cell #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WD_MASK = 8'h00
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic reg_rst,
  input wire logic wd_expire,
  input wire logic we,
  input wire logic [7:0] wmask,
  input wire logic [7:0] wdata,
  input wire logic hw_ld,
  input wire logic [7:0] hw_mask,
  input wire logic [7:0] hw_data,
  output chc_pkg::chc_cell_s q
);
  import chc_pkg::*;

  chc_cell_s r; // stored value
  chc_cell_s next_r; // value for the next edge

  // ****************************************
  // next value
  // ****************************************
  always_comb begin
    next_r = r;
    if (reg_rst) begin
      next_r.q = RESET_VAL;
    end else if (wd_expire) begin
      // only the masked bits go back to default
      next_r.q = (r.q & ~WD_MASK) | (RESET_VAL & WD_MASK);
    end else begin
      if (we) begin
        next_r.q = (r.q & ~wmask) | (wdata & wmask);
      end
      // hardware result wins over a host write in the same cycle
      if (hw_ld) begin
        next_r.q = (next_r.q & ~hw_mask) | (hw_data & hw_mask);
      end
    end
  end

  // register with synchronous reset
  always_ff @(posedge clk) begin
    if (srst) begin
      r.q <= RESET_VAL;
    end else begin
      r <= next_r;
    end
  end

  assign q = r;

endmodule : chc_reg_cell
